/* File: logic/mtm_pkg.sv */
// constants and types shared by the meter test-mode controller
// assumes a single 100 MHz clock domain
`default_nettype none
package mtm_pkg;
  // clock and timing
  localparam int CLK_KHZ      = 100_000;
  localparam int MS_TIME      = 1;
  localparam int MS_CYC       = MS_TIME * CLK_KHZ;
  localparam int DEBOUNCE_MS  = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int BLINK_MS     = 500;
  localparam int BLINK_CYC    = BLINK_MS * CLK_KHZ;
  // register map, byte addresses
  localparam int ADDR_W       = 8;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WEIGHT = 8'h04;
  localparam logic [7:0] OFS_WIDTH  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_TVAL   = 8'h10;
  localparam logic [7:0] OFS_PRESET = 8'h14;
  // control fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_FORMC_BIT = 1;
  localparam int CTRL_TEST_BIT  = 2;
  localparam int CTRL_SRC_LSB   = 4;
  // pulse weight in milliwatt-hours, width in ms
  localparam int WEIGHT_W = 16;
  localparam int WIDTH_W  = 10;
  localparam logic [15:0] WEIGHT_RESET = 16'h0708;
  localparam logic [9:0]  WIDTH_RESET  = 10'h064;
  localparam logic [9:0]  WIDTH_MIN_MS = 10'h005;
  localparam logic [9:0]  WIDTH_MAX_MS = 10'h27b;
  localparam int SRC_N = 6;
  typedef enum logic [2:0] {
    SCR_WH_DEL, SCR_WH_REC, SCR_VARH_Q12, SCR_VARH_Q34,
    SCR_VAH_Q14, SCR_VAH_Q23, SCR_DMD_ROLL, SCR_DMD_BLOCK
  } mtm_screen_t;
  typedef enum logic [2:0] {
    SRC_WH_DEL, SRC_WH_REC, SRC_VARH_DEL, SRC_VARH_REC,
    SRC_VAH_Q1, SRC_VAH_Q3
  } mtm_src_t;
endpackage
`default_nettype wire

/* File: logic/mtm_debounce.sv */
// push-button synchroniser and debouncer with press/release pulses
// assumes an active-high button level from a pin, any timing
`default_nettype none
module mtm_debounce #(
  parameter int CYC_P = mtm_pkg::DEBOUNCE_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      press_o,
  output logic      release_o
);
  import mtm_pkg::*;
  localparam int CW = $clog2(CYC_P + 1);
  logic [2:0]    sync;
  logic          level;
  logic [CW-1:0] cnt;
  wire           agree  = sync[1] == sync[2];
  wire           differ = agree && (sync[2] != level);
  wire           done   = differ && (cnt == CW'(CYC_P - 1));
  // three-stage chain; only stages two and three are compared
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync      <= 3'h0;
      level     <= 1'b0;
      cnt       <= '0;
      press_o   <= 1'b0;
      release_o <= 1'b0;
    end else if (ce_i) begin
      sync      <= {sync[1:0], pin_i};
      cnt       <= (differ && !done) ? cnt + 1'b1 : '0;
      press_o   <= done && sync[2];
      release_o <= done && !sync[2];
      if (done) begin
        level <= sync[2];
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/mtm_pulse_gen.sv */
// calibration pulse generator: energy quanta in, timed pulse out
// assumes tick_i is one pulse per milliwatt-hour, same clock
`default_nettype none
module mtm_pulse_gen #(
  parameter int MS_CYC_P = mtm_pkg::MS_CYC
) (
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  input  wire logic                          ce_i,
  input  wire logic                          en_i,
  input  wire logic                          form_c_i,
  input  wire logic                          tick_i,
  input  wire logic [mtm_pkg::WEIGHT_W-1:0]  weight_i,
  input  wire logic [mtm_pkg::WIDTH_W-1:0]   width_ms_i,
  output logic                               led_o,
  output logic                               relay_k_o,
  output logic                               relay_z_o
);
  import mtm_pkg::*;
  localparam int MW = $clog2(MS_CYC_P + 1);
  logic [WEIGHT_W-1:0] acc;
  logic [WIDTH_W-1:0]  ms_left;
  logic [MW-1:0]       ms_div;
  logic                form_state;
  wire [WEIGHT_W:0] acc_inc = {1'b0, acc} + 1'b1;
  wire fire   = en_i && tick_i && (acc_inc >= {1'b0, weight_i});
  wire ms_end = led_o && (ms_div == MW'(MS_CYC_P - 1));
  // form a closes one contact; form c swaps contacts per pulse
  assign relay_k_o = form_c_i ? form_state : led_o;
  assign relay_z_o = form_c_i && !form_state;
  // a pulse due while one is still out is dropped, not queued
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= '0;
      ms_left <= '0;
      ms_div <= '0;
      led_o <= 1'b0;
      form_state <= 1'b0;
    end else if (ce_i) begin
      acc <= !en_i ? '0 : fire ? '0 : tick_i ? acc_inc[WEIGHT_W-1:0] : acc;
      if (!en_i) begin
        led_o <= 1'b0;
      end else if (fire && !led_o) begin
        led_o <= 1'b1;
        ms_left <= width_ms_i;
        ms_div <= '0;
        form_state <= !form_state;
      end else if (ms_end) begin
        ms_div <= '0;
        ms_left <= ms_left - 1'b1;
        led_o <= (ms_left != 10'h001);
      end else if (led_o) begin
        ms_div <= ms_div + 1'b1;
      end
    end
  end
  AST_FORMA_Z: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !form_c_i |-> !relay_z_o) else $error("form a drives z");
  AST_OFF: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && !en_i) |=> !led_o) else $error("pulse while off");
  AST_FIRE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && fire && !led_o) |=> led_o) else $error("no pulse");
endmodule
`default_nettype wire

/* File: logic/mtm_test_mode_ctrl.sv */
// meter test-mode controller: pulse output, test screens, billing
// freeze; assumes energy ticks and phase flags on this clock and
// buttons arriving straight from pins
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
// Operation
// - emit calibration pulses per programmed weight
// - pulse width programmable 5 to 635 ms
// - weight defaults to 1.800 Wh
// - pulse enable and form a/c selectable
// - eight test screens in fixed order
// - blank phase indicator without voltage
// - blink indicator without current, steady with
// - test mode freezes billing register updates
// - test mode shows base units
// - no auto-scroll, advance on test press
// - pulse source follows selected test screen
// - reset button clears test values, restarts block
// - test reset keeps current screen
// - power-up always in normal mode
// - ir and port one stay available
// - presets load into billing at exit
// - no new maximum demand during test
module mtm_test_mode_ctrl #(
  parameter int MS_CYC_P       = mtm_pkg::MS_CYC,
  parameter int DEBOUNCE_CYC_P = mtm_pkg::DEBOUNCE_CYC,
  parameter int BLINK_CYC_P    = mtm_pkg::BLINK_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         nrst_i,
  input  wire logic                         ce_i,
  input  wire logic [mtm_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [31:0]                  wr_data_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [31:0]                  rd_data_o,
  input  wire logic                         test_btn_i,
  input  wire logic                         reset_btn_i,
  input  wire logic [mtm_pkg::SRC_N-1:0]    energy_tick_i,
  input  wire logic [2:0]                   volt_present_i,
  input  wire logic [2:0]                   current_flow_i,
  output logic                              led_o,
  output logic                              pulse_relay_output_k_o,
  output logic                              pulse_relay_output_z_o,
  output logic                              test_mode_o,
  output logic      [2:0]                   screen_o,
  output logic                              base_units_o,
  output logic                              autoscroll_en_o,
  output logic                              billing_update_en_o,
  output logic                              max_demand_rec_en_o,
  output logic                              block_restart_o,
  output logic      [2:0]                   phase_ind_o,
  output logic                              ir_port_en_o,
  output logic                              com1_port_en_o,
  output logic      [31:0]                  preset_value_o,
  output logic                              preset_load_o
);
  import mtm_pkg::*;
  typedef enum logic {ST_NORMAL, ST_TEST} mtm_mode_t;
  localparam int BW = $clog2(BLINK_CYC_P + 1);

  // address match used by every decode below
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // pulse source for each test screen
  function automatic mtm_src_t src_of(input mtm_screen_t s);
    case (s)
      SCR_WH_REC:   src_of = SRC_WH_REC;
      SCR_VARH_Q12: src_of = SRC_VARH_DEL;
      SCR_VARH_Q34: src_of = SRC_VARH_REC;
      SCR_VAH_Q14:  src_of = SRC_VAH_Q1;
      SCR_VAH_Q23:  src_of = SRC_VAH_Q3;
      default:      src_of = SRC_WH_DEL;
    endcase
  endfunction

  mtm_mode_t           mode;
  mtm_mode_t           next_mode;
  mtm_screen_t         screen;
  mtm_screen_t         next_screen;
  logic                pulse_en;
  logic                form_c;
  logic [2:0]          chan;
  logic [WEIGHT_W-1:0] weight;
  logic [WIDTH_W-1:0]  width_ms;
  logic [31:0]         test_value;
  logic [31:0]         next_rd_data;
  logic [BW-1:0]       blink_cnt;
  logic                blink_on;
  logic                test_press;
  logic                reset_release;

  // buttons: synchronised, debounced, one event per press
  mtm_debounce #(.CYC_P(DEBOUNCE_CYC_P)) u_test_btn (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (test_btn_i),
    .press_o   (test_press),
    .release_o ()
  );
  mtm_debounce #(.CYC_P(DEBOUNCE_CYC_P)) u_reset_btn (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (reset_btn_i),
    .press_o   (),
    .release_o (reset_release)
  );

  // register write decode
  wire wr_ctrl   = wr_i && hit(addr_i, OFS_CTRL);
  wire wr_weight = wr_i && hit(addr_i, OFS_WEIGHT);
  wire wr_width  = wr_i && hit(addr_i, OFS_WIDTH);
  wire wr_preset = wr_i && hit(addr_i, OFS_PRESET);
  wire in_test   = (mode == ST_TEST);
  wire enter     = wr_ctrl && wr_data_i[CTRL_TEST_BIT];
  wire leave     = in_test && wr_ctrl && !wr_data_i[CTRL_TEST_BIT];
  wire test_rst  = in_test && reset_release;

  // out-of-range widths are clamped rather than refused
  wire [WIDTH_W-1:0] wr_w = wr_data_i[WIDTH_W-1:0];
  wire [WIDTH_W-1:0] width_val =
    (wr_data_i[31:WIDTH_W] != '0 || wr_w > WIDTH_MAX_MS) ? WIDTH_MAX_MS :
    (wr_w < WIDTH_MIN_MS) ? WIDTH_MIN_MS : wr_w;

  // pulse source: screen in test mode, assigned channel otherwise
  wire [2:0] sel_src = in_test ? 3'(src_of(screen)) : chan;
  wire       sel_tick = (sel_src < 3'(SRC_N)) && energy_tick_i[sel_src];

  // mode sequencing: only a register write enters or leaves
  always_comb begin
    next_mode = mode;
    case (mode)
      ST_NORMAL: if (enter) next_mode = ST_TEST;
      ST_TEST:   if (leave) next_mode = ST_NORMAL;
      default:   next_mode = ST_NORMAL;
    endcase
  end

  // screen advances only on a press; a test reset leaves it alone
  always_comb begin
    next_screen = screen;
    if (!in_test && enter) begin
      next_screen = SCR_WH_DEL;
    end else if (in_test && test_press) begin
      next_screen = mtm_screen_t'(screen + 3'h1);
    end
  end

  // state resets to normal mode: a power cycle drops any test
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode   <= ST_NORMAL;
      screen <= SCR_WH_DEL;
    end else if (ce_i) begin
      mode   <= next_mode;
      screen <= next_screen;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_en       <= 1'b1;
      form_c         <= 1'b0;
      chan           <= 3'h0;
      weight         <= WEIGHT_RESET;
      width_ms       <= WIDTH_RESET;
      preset_value_o <= 32'h0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        pulse_en <= wr_data_i[CTRL_EN_BIT];
        form_c   <= wr_data_i[CTRL_FORMC_BIT];
        chan     <= wr_data_i[CTRL_SRC_LSB +: 3];
      end
      if (wr_weight) weight <= wr_data_i[WEIGHT_W-1:0];
      if (wr_width) width_ms <= width_val;
      if (wr_preset && in_test) preset_value_o <= wr_data_i;
    end
  end

  // test quantity accumulates the selected source while testing
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      test_value      <= 32'h0;
      block_restart_o <= 1'b0;
      preset_load_o   <= 1'b0;
    end else if (ce_i) begin
      block_restart_o <= test_rst || (!in_test && enter);
      preset_load_o   <= leave;
      if (test_rst || (!in_test && enter)) begin
        test_value <= 32'h0;
      end else if (in_test && sel_tick) begin
        test_value <= test_value + 32'h1;
      end
    end
  end

  // blink timebase for phases with voltage but no current
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blink_cnt <= '0;
      blink_on  <= 1'b0;
    end else if (ce_i) begin
      if (blink_cnt == BW'(BLINK_CYC_P - 1)) begin
        blink_cnt <= '0;
        blink_on  <= !blink_on;
      end else begin
        blink_cnt <= blink_cnt + 1'b1;
      end
    end
  end

  // per-phase indicator
  for (genvar g = 0; g < 3; g++) begin : g_phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        phase_ind_o[g] <= 1'b0;
      end else if (ce_i) begin
        phase_ind_o[g] <= volt_present_i[g] &&
                          (current_flow_i[g] || blink_on);
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rd_data = 32'h0;
    if (hit(addr_i, OFS_CTRL)) begin
      next_rd_data = {25'h0, chan, 1'b0, in_test, form_c, pulse_en};
    end else if (hit(addr_i, OFS_WEIGHT)) begin
      next_rd_data = {16'h0, weight};
    end else if (hit(addr_i, OFS_WIDTH)) begin
      next_rd_data = {22'h0, width_ms};
    end else if (hit(addr_i, OFS_STATUS)) begin
      next_rd_data = {25'h0, phase_ind_o, screen, in_test};
    end else if (hit(addr_i, OFS_TVAL)) begin
      next_rd_data = test_value;
    end else if (hit(addr_i, OFS_PRESET)) begin
      next_rd_data = preset_value_o;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 32'h0;
    end else if (ce_i) begin
      rd_data_o <= rd_i ? next_rd_data : 32'h0;
    end
  end

  // mode-driven outputs; billing and max demand freeze in test
  assign test_mode_o         = in_test;
  assign screen_o            = screen;
  assign base_units_o        = in_test;
  assign autoscroll_en_o     = !in_test;
  assign billing_update_en_o = !in_test;
  assign max_demand_rec_en_o = !in_test;
  assign ir_port_en_o        = 1'b1;
  assign com1_port_en_o      = 1'b1;

  mtm_pulse_gen #(.MS_CYC_P(MS_CYC_P)) u_pulse (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .en_i       (pulse_en),
    .form_c_i   (form_c),
    .tick_i     (sel_tick),
    .weight_i   (weight),
    .width_ms_i (width_ms),
    .led_o      (led_o),
    .relay_k_o  (pulse_relay_output_k_o),
    .relay_z_o  (pulse_relay_output_z_o)
  );

  // rule checks; the weight check relies on the async register reset
  AST_PWRUP_NORMAL: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $past(!nrst_i) |-> !test_mode_o && weight == WEIGHT_RESET)
    else $error("not normal with default weight after reset");
  AST_WIDTH_RANGE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    width_ms >= WIDTH_MIN_MS && width_ms <= WIDTH_MAX_MS)
    else $error("pulse width out of range");
  AST_SCREEN_STEP: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && in_test && test_press && !leave) |=>
      screen_o == 3'($past(screen_o) + 3'h1))
    else $error("screen did not step");
  AST_SCREEN_HOLD: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && in_test && !test_press) |=> $stable(screen_o))
    else $error("screen moved without press");
  AST_SRC_DEMAND: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (in_test && screen_o[2:1] == 2'b11) |-> sel_src == 3'h0)
    else $error("demand screen not on delivered wh");
  AST_TEST_RESET: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && test_rst && !test_press && !leave) |=>
      test_value == 32'h0 && block_restart_o && $stable(screen_o))
    else $error("test reset incomplete");
  AST_KEEP_SCREEN: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && test_rst && !test_press) |=> screen_o == $past(screen_o))
    else $error("reset changed screen");
  AST_BILL_FREEZE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    test_mode_o |-> !billing_update_en_o && !max_demand_rec_en_o &&
      base_units_o && !autoscroll_en_o)
    else $error("billing live in test");
  AST_COMM: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    test_mode_o |-> ir_port_en_o && com1_port_en_o)
    else $error("comm port lost in test");
  AST_PRESET: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && leave) |=> preset_load_o && !test_mode_o)
    else $error("preset not loaded at exit");
  AST_PHASE_BLANK: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && !volt_present_i[0]) |=> !phase_ind_o[0])
    else $error("phase shown without voltage");
  AST_PHASE_STEADY: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && volt_present_i[1] && current_flow_i[1]) |=> phase_ind_o[1])
    else $error("phase not steady with current");
  CVR_WRAP: cover property (@(posedge clk_i) disable iff (!nrst_i)
    in_test && screen_o == 3'h7 ##1 screen_o == 3'h0);
  CVR_RESET: cover property (@(posedge clk_i) disable iff (!nrst_i)
    test_rst && screen_o == 3'h3);
  CVR_PULSE: cover property (@(posedge clk_i) disable iff (!nrst_i)
    in_test && $rose(led_o));
  CVR_EXIT: cover property (@(posedge clk_i) disable iff (!nrst_i)
    preset_load_o);
endmodule
`default_nettype wire

/* File: verif/mtm_pulse_reader.sv */
// pulse reader model: counts calibration pulses, times the last one
// assumes led_i is a registered level on the same clock
`default_nettype none
module mtm_pulse_reader (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic led_i,
  output int        count_o,
  output int        width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  // one count per rising edge; width latched on the falling edge
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= 0;
      width_o <= 0;
      run     <= 0;
    end else if (led_i === 1'b1) begin
      run <= run + 1;
      if (run == 0) count_o <= count_o + 1;
    end else begin
      if (run != 0) width_o <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_mtm_test_mode_ctrl.sv */
// bench for the test-mode controller: bus tasks, buttons, ticks
// assumes shortened timing parameters; the reader model times pulses
`default_nettype none
module test_mtm_test_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import mtm_pkg::*;
  localparam int MSC = 4;
  logic        clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
  logic        tbtn = 0, rbtn = 0, led, pk, pz, tm, bu, asc, bil, mdr;
  logic        brs, ir, c1, pld;
  logic [7:0]  addr = '0;
  logic [31:0] wd = '0, rdat, pval, d;
  logic [5:0]  tick = '0;
  logic [2:0]  volt = '0, cur = '0, scr, ph, s0, s1;
  int          bad_count = 0, cmp_count = 0, pc, pw, restarts = 0;
  int          loads = 0, n0, src, oth;
  // clock generation
  initial forever #5 clk_i = ~clk_i;
  mtm_test_mode_ctrl #(.MS_CYC_P(MSC), .DEBOUNCE_CYC_P(3),
    .BLINK_CYC_P(4)) mtm_test_mode_ctrl_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .addr_i(addr),
    .wr_data_i(wd), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdat),
    .test_btn_i(tbtn), .reset_btn_i(rbtn), .energy_tick_i(tick),
    .volt_present_i(volt), .current_flow_i(cur), .led_o(led),
    .pulse_relay_output_k_o(pk), .pulse_relay_output_z_o(pz),
    .test_mode_o(tm), .screen_o(scr), .base_units_o(bu),
    .autoscroll_en_o(asc), .billing_update_en_o(bil),
    .max_demand_rec_en_o(mdr), .block_restart_o(brs),
    .phase_ind_o(ph), .ir_port_en_o(ir), .com1_port_en_o(c1),
    .preset_value_o(pval), .preset_load_o(pld));
  mtm_pulse_reader mtm_pulse_reader_inst (.clk_i(clk_i),
    .nrst_i(nrst_i), .led_i(led), .count_o(pc), .width_o(pw));
  // one-cycle pulses are counted as they appear
  always @(posedge clk_i) begin
    if (brs === 1'b1) restarts <= restarts + 1;
    if (pld === 1'b1) loads <= loads + 1;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr <= a;
    wd   <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdat;
  endtask
  // ticks spaced one idle cycle apart, then room for a full pulse
  task automatic ticks(int b, int n);
    repeat (n) begin
      @(posedge clk_i);
      tick <= 6'h01 << b;
      @(posedge clk_i);
      tick <= '0;
    end
    repeat (5 * MSC + 8) @(posedge clk_i);
  endtask
  // hold a pin long enough to pass the debouncer both ways
  task automatic push(bit rst);
    @(posedge clk_i);
    if (rst) begin
      rbtn <= 1'b1;
    end else begin
      tbtn <= 1'b1;
    end
    repeat (20) @(posedge clk_i);
    rbtn <= 1'b0;
    tbtn <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (50000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(OFS_WEIGHT);
    chk("weight", 32'(WEIGHT_RESET), d);
    chk("ports", 2'b11, {ir, c1});
    chk("normal", 4'b0111, {tm, asc, bil, mdr});
    wr(OFS_WIDTH, 32'h3);
    rd(OFS_WIDTH);
    chk("wmin", 32'(WIDTH_MIN_MS), d);
    wr(OFS_WIDTH, 32'h3ff);
    rd(OFS_WIDTH);
    chk("wmax", 32'(WIDTH_MAX_MS), d);
    wr(OFS_WIDTH, 32'h5);
    wr(OFS_WEIGHT, 32'h3);
    wr(OFS_CTRL, 32'h1);
    ticks(0, 3);
    chk("pulses", 1, pc);
    chk("width", 5 * MSC, pw);
    chk("forma z", 0, pz);
    // the contact state flips on every pulse, form a included
    wr(OFS_CTRL, 32'h3);
    n0 = pc;
    ticks(0, 3);
    chk("formc k", 0, pk);
    chk("formc z", 1, pz);
    ticks(0, 3);
    chk("formc k2", 1, pk);
    chk("formc z2", 0, pz);
    wr(OFS_CTRL, 32'h0);
    ticks(0, 6);
    chk("off", n0 + 2, pc);
    $display("test pulse done");
    wr(OFS_CTRL, 32'h5);
    @(negedge clk_i);
    chk("test", 5'b11000, {tm, bu, asc, bil, mdr});
    for (int s = 0; s < 9; s++) begin
      src = (s % 8 < 6) ? s % 8 : 0;
      oth = (src == 5) ? 0 : src + 1;
      chk("screen", s % 8, scr);
      n0 = pc;
      ticks(oth, 3);
      chk("foreign", n0, pc);
      ticks(src, 3);
      chk("src", n0 + 1, pc);
      chk("hold", s % 8, scr);
      push(0);
    end
    $display("test screens done");
    push(0);
    push(0);
    ticks(3, 2);
    n0 = restarts;
    push(1);
    chk("restart", n0 + 1, restarts);
    rd(OFS_TVAL);
    chk("tval", 0, d);
    rd(OFS_STATUS);
    chk("status", 32'h7, d);
    wr(OFS_PRESET, 32'h12345678);
    n0 = loads;
    wr(OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("load", n0 + 1, loads);
    chk("preset", 32'h12345678, pval);
    $display("test reset and preset done");
    wr(OFS_CTRL, 32'h5);
    push(0);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk("powerup", 5'b00001, {tm, scr, bil});
    rd(OFS_WEIGHT);
    chk("weight again", 32'(WEIGHT_RESET), d);
    $display("test power loss done");
    @(posedge clk_i);
    volt <= 3'b011;
    cur  <= 3'b001;
    repeat (4) @(posedge clk_i);
    s0 = '1;
    s1 = '0;
    repeat (40) @(negedge clk_i) begin
      s0 &= ph;
      s1 |= ph;
    end
    chk("blank", 0, s1[2]);
    chk("steady", 1, s0[0]);
    chk("blink", 2'b01, {s0[1], s1[1]});
    $display("test phases done");
    print_verdict();
  end
endmodule
`default_nettype wire
